// File: inc/ecc_map.svh
// Register offsets, field positions and timing counts for the cycle-control block
`ifndef ECC_MAP_SVH
`define ECC_MAP_SVH
// ----------------------------------------------------------------
// Register map (byte addresses on the Avalon-MM slave)
// ----------------------------------------------------------------
`define ECC_IO_RECOVERY_IDX   12'hc12
`define ECC_IO_RECOVERY_ADDR  14'h3048
`define ECC_CTRL_ADDR         14'h0000
`define ECC_STATUS_ADDR       14'h0004
`define ECC_DATA_ADDR         14'h0008
`define ECC_ADDR_W            14
// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define ECC_RECOV_LSB         0
`define ECC_RECOV_W           4
`define ECC_RECOV_RESET       8'h00
`define ECC_CTRL_GO           0
`define ECC_CTRL_KIND_LSB     1
`define ECC_CTRL_MIO          4
`define ECC_CTRL_WR           5
`define ECC_CTRL_LOCK         6
`define ECC_CTRL_LOCAL        7
`define ECC_CTRL_INTA         8
`define ECC_ST_BUSY           0
`define ECC_ST_DONE           1
`define ECC_ST_EX32           3
`define ECC_ST_EX16           4
`define ECC_ST_SLBURST        2
`define ECC_ST_LOCAL          5
`define ECC_ST_SKIPPED        6
`endif

// File: inc/ecc_pkg.sv
// Types used by the controller end of the cycle-control link
package ecc_pkg;
	typedef enum logic [1:0] {
		ECC_HOST    = 2'b00,
		ECC_ISA     = 2'b01,
		ECC_DMA     = 2'b10,
		ECC_REFRESH = 2'b11
	} ecc_kind_t;

	typedef enum logic [2:0] {
		ECC_IDLE    = 3'b000,
		ECC_RECOVER = 3'b001,
		ECC_START   = 3'b010,
		ECC_CMD     = 3'b011,
		ECC_FINISH  = 3'b100
	} ecc_state_t;
endpackage : ecc_pkg

// File: inc/ecc_if.sv
// Connector-side bus signals between the controller and an EISA slave or master
`timescale 1ns/100ps
interface ecc_if;
	logic mem_io_n;
	logic mem_io_copy_n;
	logic write_read_n;
	logic write_read_copy_n;
	logic lock_n;
	logic lock_copy_n;
	logic start_n;
	logic start_copy_n;
	logic cmd_n;
	logic master_burst_o;
	logic master_burst_copy_o;
	logic master_burst_oe;
	logic master_burst_in;
	logic slave_burst_in;
	logic slave_burst_o;
	logic slave_burst_copy_o;
	logic slave_burst_oe;
	logic ready_in;
	logic wide32_in;
	logic wide32_o;
	logic wide32_copy_o;
	logic wide32_oe;
	logic wide16_in;
	logic wide16_o;
	logic wide16_copy_o;
	logic wide16_oe;
	logic slave_ex32_n;
	logic slave_ex16_n;
	logic slave_ready;
	logic slave_burst_n;
	logic slave_ready_oe;
	logic ext_master_burst_n;
	logic ext_master_burst_oe;

	modport ctrl (
		output mem_io_n, mem_io_copy_n, write_read_n, write_read_copy_n,
		output lock_n, lock_copy_n, start_n, start_copy_n, cmd_n,
		output master_burst_o, master_burst_copy_o, master_burst_oe,
		output slave_burst_o, slave_burst_copy_o, slave_burst_oe,
		output wide32_o, wide32_copy_o, wide32_oe,
		output wide16_o, wide16_copy_o, wide16_oe,
		input  ready_in, master_burst_in, slave_burst_in, wide32_in, wide16_in
	);
	modport slave (
		input  mem_io_n, write_read_n, lock_n, start_n, cmd_n,
		input  master_burst_in,
		output slave_ex32_n, slave_ex16_n, slave_ready, slave_ready_oe,
		output slave_burst_n, ext_master_burst_n, ext_master_burst_oe
	);
endinterface : ecc_if

// File: hdl/ecc_ctrl.sv
// Cycle-control end: drives start, command and strobes, handshakes with the slave
//
// What this block does
// - M/IO from host, ISA command, high else
// - W/R from host/DMA, ISA writes, refresh low
// - Start for all masters, skip local hits in host cycles
// - Start also for assembly/disassembly cycles
// - Recovery clocks between back-to-back host I/O
// - Command from start until burst high
// - DMA read command ends on falling edge
// - Sample ready on falling edge, wait states
// - Drive master burst in host cycles
// - DMA master burst follows slave burst
// - Sample external master burst ending command
// - Sample slave burst; drive on external-master local memory hit
// - Sample EX32; drive low on external-master local memory hit
// - Sample EX16; drive at assembly end
// - All link logic on bus clock
`timescale 1ns/100ps
`include "ecc_map.svh"
module ecc_ctrl (
	// System side
	input  wire logic                     sys_clk,
	input  wire logic                     resetn,
	// Avalon-MM slave
	input  wire logic [`ECC_ADDR_W-1:0]   avs_address,
	input  wire logic                     avs_read,
	input  wire logic                     avs_write,
	input  wire logic [31:0]              avs_writedata,
	output logic      [31:0]              avs_readdata,
	output logic                          avs_waitrequest,
	// Host indications
	input  wire logic                     coprocessor_select,
	input  wire logic                     local_device_decoded,
	input  wire logic                     local_memory_hit,
	input  wire logic                     isa_io_cmd,
	input  wire logic                     isa_write_cmd,
	input  wire logic                     ext_master_active,
	input  wire logic                     assembly_cycle,
	// Link
	input  wire logic                     bus_clock_in,
	ecc_if.ctrl                           bus
);
	// ----------------------------------------------------------------
	// Registers and crossing
	// ----------------------------------------------------------------
	logic [7:0]  recov_ff;
	logic [8:0]  ctrl_ff;
	logic        req_tgl_ff;
	logic [2:0]  ack_sync_ff;
	logic        done_ff;
	logic        busy_ff;
	logic [3:0]  stat_ff;
	logic        skipped_ff;
	logic        rd_done_ff;
	logic [31:0] nxt_rdata;

	// Skip flag is decided on the system side, where the decode arrives
	logic local_hit;
	assign local_hit = coprocessor_select | local_device_decoded | avs_writedata[`ECC_CTRL_LOCAL];

	// Response after one wait cycle keeps the read data registered
	assign avs_waitrequest = (avs_read | avs_write) & ~rd_done_ff;

	always_ff @(posedge sys_clk) begin
		if (!resetn)
			rd_done_ff <= 1'b0;
		else
			rd_done_ff <= (avs_read | avs_write) & ~rd_done_ff;
	end

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		unique case (avs_address)
			`ECC_IO_RECOVERY_ADDR: nxt_rdata = {24'h00_0000, recov_ff};
			`ECC_CTRL_ADDR:        nxt_rdata = {23'h00_0000, ctrl_ff};
			`ECC_STATUS_ADDR:      nxt_rdata = {25'h000_0000, skipped_ff, local_memory_hit,
				stat_ff[3], stat_ff[2], stat_ff[0], done_ff, busy_ff};
			default:               nxt_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn)
			avs_readdata <= 32'h0000_0000;
		else if (avs_read && !rd_done_ff)
			avs_readdata <= nxt_rdata;
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			recov_ff <= `ECC_RECOV_RESET;
			ctrl_ff  <= 9'h000;
		end else if (avs_write && rd_done_ff) begin
			if (avs_address == `ECC_IO_RECOVERY_ADDR)
				recov_ff <= avs_writedata[7:0];
			// Control word must not move under a running cycle
			if (avs_address == `ECC_CTRL_ADDR && !busy_ff)
				ctrl_ff <= {avs_writedata[8:1], 1'b0};
		end
	end

	// Go strobe becomes a toggle; a go while busy is ignored
	logic go;
	assign go = avs_write && rd_done_ff && avs_address == `ECC_CTRL_ADDR
		&& avs_writedata[`ECC_CTRL_GO] && !busy_ff;

	logic ack_tgl_ff;
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			req_tgl_ff  <= 1'b0;
			ack_sync_ff <= 3'b000;
			busy_ff     <= 1'b0;
			done_ff     <= 1'b0;
			skipped_ff  <= 1'b0;
		end else begin
			ack_sync_ff <= {ack_sync_ff[1:0], ack_tgl_ff};
			if (go) begin
				skipped_ff <= local_hit && avs_writedata[2:1] == ecc_pkg::ECC_HOST;
				if (local_hit && avs_writedata[2:1] == ecc_pkg::ECC_HOST) begin
					done_ff <= 1'b1;
				end else begin
					req_tgl_ff <= ~req_tgl_ff;
					busy_ff    <= 1'b1;
					done_ff    <= 1'b0;
				end
			end else if (busy_ff && ack_sync_ff[2] != ack_sync_ff[1]) begin
				busy_ff <= 1'b0;
				done_ff <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Link domain
	// ----------------------------------------------------------------
	logic [1:0] req_sync_ff;
	logic       req_seen_ff;
	logic [1:0] lhit_sync_ff;
	ecc_pkg::ecc_state_t state_ff;
	logic [3:0] wait_ff;
	logic       io_prev_ff;
	logic       cmd_ff;
	logic       cmd_fall_hold_ff;
	logic       rdy_fe_ff;
	logic       lock_fe_ff;
	logic       wide16_fe_ff;
	ecc_pkg::ecc_kind_t kind;

	// Control word is stable while the toggle crosses
	assign kind = ecc_pkg::ecc_kind_t'(ctrl_ff[2:1]);

	always_ff @(posedge bus_clock_in) begin
		if (!resetn) begin
			req_sync_ff  <= 2'b00;
			lhit_sync_ff <= 2'b00;
		end else begin
			req_sync_ff  <= {req_sync_ff[0], req_tgl_ff};
			lhit_sync_ff <= {lhit_sync_ff[0], local_memory_hit};
		end
	end

	always_ff @(posedge bus_clock_in) begin
		if (!resetn) begin
			state_ff    <= ecc_pkg::ECC_IDLE;
			req_seen_ff <= 1'b0;
			ack_tgl_ff  <= 1'b0;
			wait_ff     <= 4'h0;
			io_prev_ff  <= 1'b0;
			cmd_ff      <= 1'b0;
			stat_ff     <= 4'h0;
		end else begin
			unique case (state_ff)
				ecc_pkg::ECC_IDLE: if (req_sync_ff[1] != req_seen_ff) begin
					req_seen_ff <= req_sync_ff[1];
					wait_ff  <= recov_ff[`ECC_RECOV_W-1:0];
					state_ff <= (io_prev_ff && kind == ecc_pkg::ECC_HOST
						&& (!ctrl_ff[`ECC_CTRL_MIO] || ctrl_ff[`ECC_CTRL_INTA])
						&& recov_ff[`ECC_RECOV_W-1:0] != 4'h0)
						? ecc_pkg::ECC_RECOVER : ecc_pkg::ECC_START;
				end
				// Exactly the programmed count of clocks is spent here
				ecc_pkg::ECC_RECOVER: begin
					if (wait_ff == 4'h1)
						state_ff <= ecc_pkg::ECC_START;
					else
						wait_ff <= wait_ff - 4'h1;
				end
				ecc_pkg::ECC_START: begin
					cmd_ff   <= 1'b1;
					state_ff <= ecc_pkg::ECC_CMD;
					stat_ff  <= {~bus.wide16_in, ~bus.wide32_in, 1'b0, ~bus.slave_burst_in};
				end
				ecc_pkg::ECC_CMD: if (rdy_fe_ff && bus.master_burst_in) begin
					cmd_ff     <= 1'b0;
					io_prev_ff <= kind == ecc_pkg::ECC_HOST
						&& (!ctrl_ff[`ECC_CTRL_MIO] || ctrl_ff[`ECC_CTRL_INTA]);
					state_ff   <= ecc_pkg::ECC_FINISH;
				end
				ecc_pkg::ECC_FINISH: begin
					ack_tgl_ff <= ~ack_tgl_ff;
					state_ff   <= ecc_pkg::ECC_IDLE;
				end
				default: state_ff <= ecc_pkg::ECC_IDLE;
			endcase
		end
	end

	always_ff @(negedge bus_clock_in) begin
		if (!resetn) begin
			rdy_fe_ff        <= 1'b0;
			lock_fe_ff       <= 1'b0;
			cmd_fall_hold_ff <= 1'b0;
			wide16_fe_ff     <= 1'b0;
		end else begin
			if (cmd_ff && (!bus.wide16_in || !bus.wide32_in))
				rdy_fe_ff <= bus.ready_in;
			else
				rdy_fe_ff <= cmd_ff;
			if (state_ff == ecc_pkg::ECC_START && ctrl_ff[`ECC_CTRL_LOCK]
				&& kind == ecc_pkg::ECC_HOST)
				lock_fe_ff <= 1'b1;
			else if (!cmd_ff && state_ff != ecc_pkg::ECC_START)
				lock_fe_ff <= 1'b0;
			cmd_fall_hold_ff <= cmd_ff && kind == ecc_pkg::ECC_DMA && !ctrl_ff[`ECC_CTRL_WR];
			wide16_fe_ff <= assembly_cycle && state_ff == ecc_pkg::ECC_FINISH;
		end
	end

	// ----------------------------------------------------------------
	// Pin drive
	// ----------------------------------------------------------------
	logic mio;
	logic wr;
	always_comb begin
		unique case (kind)
			ecc_pkg::ECC_HOST: begin
				mio = ctrl_ff[`ECC_CTRL_MIO];
				wr  = ctrl_ff[`ECC_CTRL_WR];
			end
			ecc_pkg::ECC_ISA: begin
				mio = ~isa_io_cmd;
				wr  = isa_write_cmd;
			end
			ecc_pkg::ECC_DMA: begin
				mio = 1'b1;
				wr  = ctrl_ff[`ECC_CTRL_WR];
			end
			ecc_pkg::ECC_REFRESH: begin
				mio = 1'b1;
				wr  = 1'b0;
			end
		endcase
	end

	assign bus.mem_io_n          = mio;
	assign bus.mem_io_copy_n     = mio;
	assign bus.write_read_n      = wr;
	assign bus.write_read_copy_n = wr;
	assign bus.lock_n            = ~lock_fe_ff;
	assign bus.lock_copy_n       = ~lock_fe_ff;
	assign bus.start_n           = state_ff != ecc_pkg::ECC_START;
	assign bus.start_copy_n      = state_ff != ecc_pkg::ECC_START;
	assign bus.cmd_n             = ~(cmd_ff | cmd_fall_hold_ff);
	logic mb;
	assign mb = (kind == ecc_pkg::ECC_HOST) | (kind == ecc_pkg::ECC_DMA & ~bus.slave_burst_in);
	// Released once ready is seen, so command can end at the next rising edge
	assign bus.master_burst_o      = ~(mb & cmd_ff & ~rdy_fe_ff);
	assign bus.master_burst_copy_o = ~(mb & cmd_ff & ~rdy_fe_ff);
	assign bus.master_burst_oe     = ~ext_master_active & state_ff != ecc_pkg::ECC_IDLE;
	// slave burst and EX32 driven low on a local memory hit by an external master
	assign bus.slave_burst_o      = 1'b0;
	assign bus.slave_burst_copy_o = 1'b0;
	assign bus.slave_burst_oe     = ext_master_active & lhit_sync_ff[1];
	assign bus.wide32_o           = 1'b0;
	assign bus.wide32_copy_o      = 1'b0;
	assign bus.wide32_oe          = ext_master_active & lhit_sync_ff[1];
	assign bus.wide16_o           = 1'b0;
	assign bus.wide16_copy_o      = 1'b0;
	assign bus.wide16_oe          = wide16_fe_ff;
endmodule : ecc_ctrl

// File: hdl/ecc_slave.sv
// Slave end: answers size, burst and ready for each started cycle
`timescale 1ns/100ps
module ecc_slave #(
	parameter int WAITS = 2
) (
	// Link
	input  wire logic bus_clock_in,
	input  wire logic resetn,
	ecc_if.slave      bus,
	// User side
	input  wire logic cfg_ex32,
	input  wire logic cfg_ex16,
	input  wire logic cfg_burst,
	output logic      seen_write_ff,
	output logic      seen_mem_ff,
	output logic      seen_lock_ff
);
	initial begin
		if (WAITS < 0 || WAITS > 15)
			$error("WAITS out of range");
	end

	logic [3:0] cnt_ff;
	always_ff @(posedge bus_clock_in) begin
		if (!resetn) begin
			cnt_ff        <= 4'h0;
			seen_write_ff <= 1'b0;
			seen_mem_ff   <= 1'b0;
			seen_lock_ff  <= 1'b0;
		end else if (!bus.start_n) begin
			cnt_ff        <= 4'(WAITS);
			seen_write_ff <= bus.write_read_n;
			seen_mem_ff   <= bus.mem_io_n;
			seen_lock_ff  <= ~bus.lock_n;
		end else if (!bus.cmd_n && cnt_ff != 4'h0) begin
			cnt_ff <= cnt_ff - 4'h1;
		end
	end

	assign bus.slave_ex32_n        = ~cfg_ex32;
	assign bus.slave_ex16_n        = ~cfg_ex16;
	assign bus.slave_ready         = 1'b0;
	assign bus.slave_ready_oe      = !bus.cmd_n && cnt_ff != 4'h0;
	assign bus.slave_burst_n       = ~cfg_burst;
	assign bus.ext_master_burst_n  = 1'b1;
	assign bus.ext_master_burst_oe = 1'b0;
endmodule : ecc_slave

// File: verif/ecc_link_checker.sv
// Concurrent checks on the connector signals between the two ends
`timescale 1ns/100ps
module ecc_link_checker (
	// Link clock and reset
	input wire logic bus_clock_in,
	input wire logic resetn,
	// Cycle strobes and their copies
	input wire logic start_n,
	input wire logic start_copy_n,
	input wire logic cmd_n,
	input wire logic lock_n,
	input wire logic lock_copy_n,
	input wire logic mem_io_n,
	input wire logic mem_io_copy_n,
	// Resolved handshake wires
	input wire logic ready_in,
	input wire logic master_burst_in,
	input wire logic wide16_in,
	input wire logic wide32_in
);
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking @(posedge bus_clock_in); endclocking
	default disable iff (!resetn);
	sequence start_seen;
		$fell(start_n);
	endsequence
	sequence cmd_taken;
		start_n && !cmd_n;
	endsequence
	copy_match_a: assert property (start_copy_n == start_n && lock_copy_n == lock_n
		&& mem_io_copy_n == mem_io_n) else $error("copy pin differs from primary");
	start_pulse_a: assert property (start_seen |=> start_n)
		else $error("start longer than one bus clock");
	cmd_start_a: assert property (start_seen |=> cmd_taken)
		else $error("command did not follow start");
	cmd_hold_a: assert property (!cmd_n && !master_burst_in |=> !cmd_n)
		else $error("command ended while burst low");
	// Bounded so that a stuck command shows up
	cmd_bound_a: assert property ($fell(cmd_n) |-> ##[1:60] cmd_n)
		else $error("command never ended");
	ready_wait_a: assert property (@(negedge bus_clock_in) !cmd_n && !ready_in
		&& !(wide16_in && wide32_in) |=> !cmd_n) else $error("wait state ignored");
	lock_end_a: assert property (@(negedge bus_clock_in) $rose(cmd_n) && !lock_n
		|=> lock_n) else $error("lock not released");
	lock_begin_a: assert property (@(negedge bus_clock_in) $fell(lock_n)
		|-> !$past(start_n)) else $error("lock began outside start");
endmodule : ecc_link_checker

// File: verif/tb.sv
// Self-checking bench joining the controller end and the slave end
`timescale 1ns/100ps
`include "ecc_map.svh"
module tb;
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
	// ----------------------------------------------------------------
	// Signals and instances
	// ----------------------------------------------------------------
	logic                   sys_clk = 0, bus_clock_in = 0, resetn = 0;
	logic [`ECC_ADDR_W-1:0] avs_address = '0;
	logic                   avs_read = 0, avs_write = 0, avs_waitrequest;
	logic [31:0]            avs_writedata = '0, avs_readdata, rd;
	logic                   coprocessor_select = 0, local_device_decoded = 0;
	logic                   local_memory_hit = 0, isa_io_cmd = 0, isa_write_cmd = 0;
	logic                   ext_master_active = 0, assembly_cycle = 0;
	logic                   cfg_ex32 = 1, cfg_ex16 = 0, cfg_burst = 0;
	logic                   seen_write_ff, seen_mem_ff, seen_lock_ff;
	int                     failures = 0, compares = 0, starts = 0, gap = 0, idle = 0;
	int                     mb_lows = 0, w16_drops = 0;
	logic                   cmd_rise_clk;
	ecc_if bus ();
	always #25 sys_clk = ~sys_clk;
	always #24 bus_clock_in = ~bus_clock_in;
	// Open-drain wires rest high when nobody pulls them
	assign bus.ready_in = bus.slave_ready_oe ? bus.slave_ready : 1'b1;
	assign bus.master_burst_in = (bus.master_burst_oe ? bus.master_burst_o : 1'b1)
		& (bus.ext_master_burst_oe ? bus.ext_master_burst_n : 1'b1);
	assign bus.slave_burst_in = (bus.slave_burst_oe ? bus.slave_burst_o : 1'b1) & bus.slave_burst_n;
	assign bus.wide32_in = (bus.wide32_oe ? bus.wide32_o : 1'b1) & bus.slave_ex32_n;
	assign bus.wide16_in = (bus.wide16_oe ? bus.wide16_o : 1'b1) & bus.slave_ex16_n;
	ecc_ctrl u_ecc_ctrl (.sys_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .coprocessor_select, .local_device_decoded,
		.local_memory_hit, .isa_io_cmd, .isa_write_cmd, .ext_master_active, .assembly_cycle,
		.bus_clock_in, .bus(bus));
	ecc_slave u_ecc_slave (.bus_clock_in, .resetn, .bus(bus), .cfg_ex32, .cfg_ex16, .cfg_burst,
		.seen_write_ff, .seen_mem_ff, .seen_lock_ff);
	ecc_link_checker u_ecc_link_checker (.bus_clock_in, .resetn, .start_n(bus.start_n),
		.start_copy_n(bus.start_copy_n), .cmd_n(bus.cmd_n), .lock_n(bus.lock_n),
		.lock_copy_n(bus.lock_copy_n), .mem_io_n(bus.mem_io_n),
		.mem_io_copy_n(bus.mem_io_copy_n), .ready_in(bus.ready_in),
		.master_burst_in(bus.master_burst_in), .wide16_in(bus.wide16_in),
		.wide32_in(bus.wide32_in));
	// Idle bus clocks since the last start, latched at the next start
	always @(posedge bus_clock_in) begin
		if (!bus.start_n) begin
			gap <= idle;
			idle <= 0;
		end else if (bus.cmd_n)
			idle <= idle + 1;
	end
	always @(negedge bus.start_n) starts++;
	// Burst drops, size drops on a low clock, and clock level when command ends
	always @(negedge bus.master_burst_in) mb_lows++;
	always @(negedge bus.wide16_in) if (!bus_clock_in) w16_drops++;
	always @(posedge bus.cmd_n) cmd_rise_clk = bus_clock_in;
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic avs(input logic wr, input logic [`ECC_ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		rd = avs_readdata;
		if (n >= 50) failures++;
		avs_write <= 0;
		avs_read <= 0;
		@(posedge sys_clk);
	endtask : avs
	task automatic run(input logic [31:0] c);
		int n;
		n = 0;
		avs(1, `ECC_CTRL_ADDR, c);
		do begin
			avs(0, `ECC_STATUS_ADDR, 0);
			n++;
		end while ((rd[`ECC_ST_BUSY] !== 1'b0 || rd[`ECC_ST_DONE] !== 1'b1) && n < 200);
		if (n >= 200) failures++;
	endtask : run
	task automatic t_regs();
		avs(0, `ECC_IO_RECOVERY_ADDR, 0);
		`CHK(rd[7:0], `ECC_RECOV_RESET)
		avs(1, `ECC_IO_RECOVERY_ADDR, 32'h0000000f);
		avs(0, `ECC_IO_RECOVERY_ADDR, 0);
		`CHK(rd[3:0], 4'hf)
		avs(0, 14'h0100, 0);
		`CHK(rd, 32'h00000000)
	endtask : t_regs
	// Control bits are lock, write, mem; results are mem, write, lock
	task automatic t_kinds();
		logic [2:0] cb [4];
		logic [2:0] ex [4];
		int         s;
		int         m;
		cb = '{3'b111, 3'b001, 3'b010, 3'b010};
		ex = '{3'b111, 3'b010, 3'b110, 3'b100};
		for (int k = 0; k < 4; k++) begin
			isa_io_cmd <= (k == 1);
			isa_write_cmd <= (k == 1);
			cfg_ex32 <= (k != 3);
			cfg_ex16 <= (k == 3);
			cfg_burst <= (k == 2);
			s = starts;
			m = mb_lows;
			run({25'h0, cb[k], 1'b0, 2'(k), 1'b1});
			`CHK(starts, s + 1)
			`CHK({seen_mem_ff, seen_write_ff, seen_lock_ff}, ex[k])
			`CHK(mb_lows - m, (k == 0 || k == 2) ? 1 : 0)
			`CHK(rd[`ECC_ST_SLBURST], (k == 2))
			`CHK(rd[`ECC_ST_EX32], (k != 3))
			`CHK(rd[`ECC_ST_EX16], (k == 3))
		end
	endtask : t_kinds
	task automatic t_skip();
		int s;
		for (int i = 0; i < 2; i++) begin
			coprocessor_select <= (i == 0);
			local_device_decoded <= (i == 1);
			s = starts;
			run(32'h00000031);
			`CHK(starts, s)
			`CHK(rd[`ECC_ST_SKIPPED], 1'b1)
		end
		coprocessor_select <= 0;
		local_device_decoded <= 0;
	endtask : t_skip
	// Software latency jitters by a few clocks, so gaps are compared with a margin
	task automatic t_recov();
		int g;
		run(32'h00000031);
		run(32'h00000021);
		g = gap;
		run(32'h00000021);
		`CHK(gap >= g + 10 && gap <= g + 20, 1'b1)
		`CHK(cmd_rise_clk, 1'b1)
		run(32'h00000005);
		`CHK(cmd_rise_clk, 1'b0)
	endtask : t_recov
	task automatic t_local();
		ext_master_active <= 1;
		local_memory_hit <= 1;
		repeat (8) @(posedge sys_clk);
		`CHK(bus.wide32_in, 1'b0)
		`CHK(bus.slave_burst_in, 1'b0)
		avs(0, `ECC_STATUS_ADDR, 0);
		`CHK(rd[`ECC_ST_LOCAL], 1'b1)
		ext_master_active <= 0;
		local_memory_hit <= 0;
		repeat (8) @(posedge sys_clk);
		`CHK(bus.wide32_in, 1'b1)
	endtask : t_local
	task automatic t_asm();
		int w;
		int s;
		cfg_ex16 <= 0;
		cfg_ex32 <= 1;
		assembly_cycle <= 1;
		w = w16_drops;
		s = starts;
		run(32'h00000011);
		`CHK(w16_drops, w + 1)
		`CHK(starts, s + 1)
		assembly_cycle <= 0;
	endtask : t_asm
	task automatic summarize();
		$display("failures=%0d compares=%0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize
	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (16) @(posedge sys_clk);
		resetn <= 1;
		@(posedge sys_clk);
		t_regs();
		t_kinds();
		t_skip();
		t_recov();
		t_local();
		t_asm();
		summarize();
	end
	initial begin
		#2000000;
		failures++;
		summarize();
	end
endmodule : tb
